// [logic/bce_pkg.sv]
// constants, opcodes and state codes for the control-flow execution block
package bce_pkg;

   localparam int PC_W = 16;
   localparam int DATA_W = 8;
   localparam int OFS_W = 12;

   // reset values
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [7:0] STATUS_RST = 8'h00;

   // status register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // cycle counts per instruction
   localparam logic [2:0] CYC_SEQ = 3'h1;
   localparam logic [2:0] CYC_JUMP_REL = 3'h2;
   localparam logic [2:0] CYC_JUMP_PTR = 3'h2;
   localparam logic [2:0] CYC_JUMP_ABS = 3'h3;
   localparam logic [2:0] CYC_CALL_REL = 3'h3;
   localparam logic [2:0] CYC_CALL_PTR = 3'h3;
   localparam logic [2:0] CYC_CALL_ABS = 3'h4;
   localparam logic [2:0] CYC_RET = 3'h4;
   localparam logic [2:0] CYC_RETURN_FROM_INTERRUPT = 3'h4;
   localparam logic [2:0] CYC_CMP = 3'h1;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
   localparam logic [2:0] CYC_BR_TAKEN = 3'h2;

   // program counter steps
   localparam logic [15:0] STEP_SEQ = 16'h0001;
   localparam logic [15:0] STEP_SKIP_ONE = 16'h0002;
   localparam logic [15:0] STEP_SKIP_TWO = 16'h0003;
   localparam logic [15:0] STEP_WORD2 = 16'h0002;

   typedef enum logic [4:0] {
      OP_NONE                   = 5'h00,
      OP_JUMP_RELATIVE          = 5'h01,
      OP_JUMP_VIA_POINTER       = 5'h02,
      OP_JUMP_ABSOLUTE          = 5'h03,
      OP_CALL_RELATIVE          = 5'h04,
      OP_CALL_VIA_POINTER       = 5'h05,
      OP_CALL_ABSOLUTE          = 5'h06,
      OP_RETURN_FROM_SUBROUTINE = 5'h07,
      OP_RETURN_FROM_INTERRUPT  = 5'h08,
      OP_COMPARE_SKIP_EQUAL     = 5'h09,
      OP_COMPARE_WITH_CARRY_IN  = 5'h0A,
      OP_COMPARE_IMMEDIATE      = 5'h0B,
      OP_SKIP_REG_BIT_CLEAR     = 5'h0C,
      OP_SKIP_REG_BIT_SET       = 5'h0D,
      OP_SKIP_IO_BIT_CLEAR      = 5'h0E,
      OP_SKIP_IO_BIT_SET        = 5'h0F,
      OP_BRANCH_FLAG_SET        = 5'h10,
      OP_BRANCH_FLAG_CLEAR      = 5'h11
   } bce_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } bce_state_t;

endpackage : bce_pkg

// [logic/bce_cmp_if.sv]
// operand and flag bundle between the executor and its compare unit
`timescale 1ns/1ps
interface bce_cmp_if;
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic borrow_in;
   logic flag_z;
   logic flag_n;
   logic flag_v;
   logic flag_c;
   logic flag_h;

   modport exec (output minuend, output subtrahend, output borrow_in,
                 input flag_z, input flag_n, input flag_v, input flag_c, input flag_h);
   modport alu (input minuend, input subtrahend, input borrow_in,
                output flag_z, output flag_n, output flag_v, output flag_c, output flag_h);
endinterface : bce_cmp_if

// [logic/bce_cmp_alu.sv]
// subtract-and-flag unit for the compare instructions; result is discarded
`timescale 1ns/1ps
module bce_cmp_alu (
   bce_cmp_if.alu cmp
);
   logic [8:0] diff;
   logic [7:0] a;
   logic [7:0] b;
   logic [7:0] r;

   always_comb begin
      a = cmp.minuend;
      b = cmp.subtrahend;
      diff = {1'b0, a} - {1'b0, b} - {8'h00, cmp.borrow_in};
      r = diff[7:0];
      cmp.flag_z = (r == 8'h00);
      cmp.flag_n = r[7];
      cmp.flag_v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      cmp.flag_c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      cmp.flag_h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
   end
endmodule : bce_cmp_alu

// [logic/bce_exec.sv]
// control-flow and compare execution unit of the 8-bit core
// Functional notes
// - relative jump loads pc+k+1, no flag change, two cycles.
// - jump via pointer loads pc from Z pair, no flags, two cycles.
// - absolute jump loads the instruction address, no flags, three cycles.
// - relative call sets pc+k+1, flags untouched, three cycles.
// - call via pointer sets pc from Z pair, flags untouched, three cycles.
// - absolute call sets pc to instruction address, no flags, four cycles.
// - subroutine return reloads pc from stack, no flags, four cycles.
// - interrupt return reloads pc from stack, sets I flag only, four cycles.
// - compare-skip-equal advances pc by 2 or 3 when equal, no flags.
// - compare with carry does Rd-Rr-C, updates Z N V C H, one cycle.
// - compare immediate does Rd-K, updates Z N V C H, one cycle.
// - skip when selected working-register bit is 0, no flags.
// - skip when selected working-register bit is 1, no flags.
// - skip when addressed I/O bit is 0, no flags.
// - skip when addressed I/O bit is 1, no flags.
// - branch adds k+1 when selected status bit is 1, one or two cycles.
// - branch adds k+1 when selected status bit is 0, one or two cycles.
`timescale 1ns/1ps
module bce_exec (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic INSTR_VALID_IN,
   input wire logic [4:0] OPCODE_IN,
   input wire logic [11:0] OFFSET_IN,
   input wire logic [15:0] ABS_ADDR_IN,
   input wire logic [15:0] Z_PTR_IN,
   input wire logic [15:0] STACK_PC_IN,
   input wire logic [7:0] RD_IN,
   input wire logic [7:0] RR_IN,
   input wire logic [2:0] BIT_SEL_IN,
   input wire logic IO_BIT_IN,
   input wire logic NEXT_TWO_WORD_IN,
   input wire logic [7:0] STATUS_IN,
   output logic [15:0] PC_OUT,
   output logic [7:0] STATUS_OUT,
   output logic STATUS_WE_OUT,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic FLUSH_OUT,
   output logic PUSH_OUT,
   output logic POP_OUT,
   output logic [15:0] RET_ADDR_OUT
);

   bce_cmp_if cmp ();

   bce_cmp_alu u_cmp_alu (
      .cmp (cmp.alu)
   );

   bce_pkg::bce_op_t op;
   bce_pkg::bce_state_t state_r;
   bce_pkg::bce_state_t state_nxt;

   logic accept;
   logic fin_late;
   logic [2:0] cnt_r;
   logic [2:0] cyc_nxt;
   logic [15:0] pc_r;
   logic [15:0] pc_nxt;
   logic [15:0] pc_pend_r;
   logic [15:0] offset_ext;
   logic [15:0] rel_target;
   logic [7:0] status_nxt;
   logic [7:0] status_pend_r;
   logic status_we_nxt;
   logic status_we_pend_r;
   logic flush_nxt;
   logic flush_pend_r;
   logic push_nxt;
   logic pop_nxt;
   logic [15:0] ret_addr_nxt;
   logic cond;
   logic skip_step_two;

   assign op = bce_pkg::bce_op_t'(OPCODE_IN);
   assign accept = INSTR_VALID_IN & (state_r == bce_pkg::ST_IDLE);
   assign fin_late = (state_r == bce_pkg::ST_EXEC) & (cnt_r == 3'h1);
   assign offset_ext = {{4{OFFSET_IN[11]}}, OFFSET_IN};
   assign rel_target = pc_r + offset_ext + bce_pkg::STEP_SEQ;
   assign skip_step_two = NEXT_TWO_WORD_IN;

   // compare operands: carry only enters the subtraction for compare-with-carry
   always_comb begin
      cmp.minuend = RD_IN;
      cmp.subtrahend = RR_IN;
      cmp.borrow_in = (op == bce_pkg::OP_COMPARE_WITH_CARRY_IN) & STATUS_IN[bce_pkg::FLAG_C];
   end

   // skip or branch condition for the current instruction
   always_comb begin
      case (op)
         bce_pkg::OP_COMPARE_SKIP_EQUAL: cond = (RD_IN == RR_IN);
         bce_pkg::OP_SKIP_REG_BIT_CLEAR: cond = ~RR_IN[BIT_SEL_IN];
         bce_pkg::OP_SKIP_REG_BIT_SET: cond = RR_IN[BIT_SEL_IN];
         bce_pkg::OP_SKIP_IO_BIT_CLEAR: cond = ~IO_BIT_IN;
         bce_pkg::OP_SKIP_IO_BIT_SET: cond = IO_BIT_IN;
         bce_pkg::OP_BRANCH_FLAG_SET: cond = STATUS_IN[BIT_SEL_IN];
         bce_pkg::OP_BRANCH_FLAG_CLEAR: cond = ~STATUS_IN[BIT_SEL_IN];
         default: cond = 1'b0;
      endcase
   end

   // next pc, cycle count and side effects, decided at acceptance
   always_comb begin
      pc_nxt = pc_r + bce_pkg::STEP_SEQ;
      cyc_nxt = bce_pkg::CYC_SEQ;
      status_nxt = STATUS_IN;
      status_we_nxt = 1'b0;
      flush_nxt = 1'b0;
      push_nxt = 1'b0;
      pop_nxt = 1'b0;
      ret_addr_nxt = pc_r + bce_pkg::STEP_SEQ;
      case (op)
         bce_pkg::OP_JUMP_RELATIVE: begin
            pc_nxt = rel_target;
            cyc_nxt = bce_pkg::CYC_JUMP_REL;
            flush_nxt = 1'b1;
         end
         bce_pkg::OP_JUMP_VIA_POINTER: begin
            pc_nxt = Z_PTR_IN;
            cyc_nxt = bce_pkg::CYC_JUMP_PTR;
            flush_nxt = 1'b1;
         end
         bce_pkg::OP_JUMP_ABSOLUTE: begin
            pc_nxt = ABS_ADDR_IN;
            cyc_nxt = bce_pkg::CYC_JUMP_ABS;
            flush_nxt = 1'b1;
         end
         bce_pkg::OP_CALL_RELATIVE: begin
            pc_nxt = rel_target;
            cyc_nxt = bce_pkg::CYC_CALL_REL;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
         end
         bce_pkg::OP_CALL_VIA_POINTER: begin
            pc_nxt = Z_PTR_IN;
            cyc_nxt = bce_pkg::CYC_CALL_PTR;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
         end
         bce_pkg::OP_CALL_ABSOLUTE: begin
            pc_nxt = ABS_ADDR_IN;
            cyc_nxt = bce_pkg::CYC_CALL_ABS;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
            // the call is two words long, so return past its second word
            ret_addr_nxt = pc_r + bce_pkg::STEP_WORD2;
         end
         bce_pkg::OP_RETURN_FROM_SUBROUTINE: begin
            pc_nxt = STACK_PC_IN;
            cyc_nxt = bce_pkg::CYC_RET;
            flush_nxt = 1'b1;
            pop_nxt = 1'b1;
         end
         bce_pkg::OP_RETURN_FROM_INTERRUPT: begin
            pc_nxt = STACK_PC_IN;
            cyc_nxt = bce_pkg::CYC_RETURN_FROM_INTERRUPT;
            status_nxt[bce_pkg::FLAG_I] = 1'b1;
            status_we_nxt = 1'b1;
            flush_nxt = 1'b1;
            pop_nxt = 1'b1;
         end
         bce_pkg::OP_COMPARE_WITH_CARRY_IN,
         bce_pkg::OP_COMPARE_IMMEDIATE: begin
            cyc_nxt = bce_pkg::CYC_CMP;
            status_nxt[bce_pkg::FLAG_Z] = cmp.flag_z;
            status_nxt[bce_pkg::FLAG_N] = cmp.flag_n;
            status_nxt[bce_pkg::FLAG_V] = cmp.flag_v;
            status_nxt[bce_pkg::FLAG_C] = cmp.flag_c;
            status_nxt[bce_pkg::FLAG_H] = cmp.flag_h;
            status_we_nxt = 1'b1;
         end
         bce_pkg::OP_COMPARE_SKIP_EQUAL,
         bce_pkg::OP_SKIP_REG_BIT_CLEAR,
         bce_pkg::OP_SKIP_REG_BIT_SET,
         bce_pkg::OP_SKIP_IO_BIT_CLEAR,
         bce_pkg::OP_SKIP_IO_BIT_SET: begin
            if (cond && skip_step_two) begin
               pc_nxt = pc_r + bce_pkg::STEP_SKIP_TWO;
               cyc_nxt = bce_pkg::CYC_SKIP_TWO;
               flush_nxt = 1'b1;
            end else if (cond) begin
               pc_nxt = pc_r + bce_pkg::STEP_SKIP_ONE;
               cyc_nxt = bce_pkg::CYC_SKIP_ONE;
               flush_nxt = 1'b1;
            end
         end
         bce_pkg::OP_BRANCH_FLAG_SET,
         bce_pkg::OP_BRANCH_FLAG_CLEAR: begin
            if (cond) begin
               pc_nxt = rel_target;
               cyc_nxt = bce_pkg::CYC_BR_TAKEN;
               flush_nxt = 1'b1;
            end
         end
         default: begin
            pc_nxt = pc_r + bce_pkg::STEP_SEQ;
         end
      endcase
   end

   // sequencer: one-cycle instructions finish at the accepting edge
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bce_pkg::ST_IDLE: begin
            if (accept && (cyc_nxt != bce_pkg::CYC_SEQ)) begin
               state_nxt = bce_pkg::ST_EXEC;
            end
         end
         bce_pkg::ST_EXEC: begin
            if (fin_late) begin
               state_nxt = bce_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = bce_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_r <= bce_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // remaining cycles of a multi-cycle instruction
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cnt_r <= 3'h0;
      end else if (accept) begin
         cnt_r <= cyc_nxt - 3'h1;
      end else if (state_r == bce_pkg::ST_EXEC) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end

   // results are held back so pc and flags change only when the instruction ends
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pc_pend_r <= bce_pkg::PC_RST;
         status_pend_r <= bce_pkg::STATUS_RST;
         status_we_pend_r <= 1'b0;
         flush_pend_r <= 1'b0;
      end else if (accept) begin
         pc_pend_r <= pc_nxt;
         status_pend_r <= status_nxt;
         status_we_pend_r <= status_we_nxt;
         flush_pend_r <= flush_nxt;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pc_r <= bce_pkg::PC_RST;
      end else if (accept && (cyc_nxt == bce_pkg::CYC_SEQ)) begin
         pc_r <= pc_nxt;
      end else if (fin_late) begin
         pc_r <= pc_pend_r;
      end
   end

   // status write-back; untouched flags are echoed so no flag changes by accident
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         STATUS_OUT <= bce_pkg::STATUS_RST;
         STATUS_WE_OUT <= 1'b0;
      end else if (accept && (cyc_nxt == bce_pkg::CYC_SEQ)) begin
         STATUS_OUT <= status_nxt;
         STATUS_WE_OUT <= status_we_nxt;
      end else if (fin_late) begin
         STATUS_OUT <= status_pend_r;
         STATUS_WE_OUT <= status_we_pend_r;
      end else begin
         STATUS_WE_OUT <= 1'b0;
      end
   end

   // completion and flush pulses
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         DONE_OUT <= 1'b0;
         FLUSH_OUT <= 1'b0;
      end else begin
         DONE_OUT <= (accept && (cyc_nxt == bce_pkg::CYC_SEQ)) || fin_late;
         FLUSH_OUT <= fin_late && flush_pend_r;
      end
   end

   // stack requests go out at acceptance so the stack has the spare cycles to act
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         PUSH_OUT <= 1'b0;
         POP_OUT <= 1'b0;
         RET_ADDR_OUT <= bce_pkg::PC_RST;
      end else begin
         PUSH_OUT <= accept && push_nxt;
         POP_OUT <= accept && pop_nxt;
         if (accept && push_nxt) begin
            RET_ADDR_OUT <= ret_addr_nxt;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         BUSY_OUT <= 1'b0;
      end else begin
         BUSY_OUT <= (state_nxt == bce_pkg::ST_EXEC);
      end
   end

   assign PC_OUT = pc_r;

endmodule : bce_exec

// [verif/bce_exec_monitor.sv]
// assertion checker on the ports of the control-flow execution block
`timescale 1ns/1ps
module bce_exec_monitor (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic INSTR_VALID_IN,
   input wire logic [4:0] OPCODE_IN,
   input wire logic [11:0] OFFSET_IN,
   input wire logic [15:0] ABS_ADDR_IN,
   input wire logic [15:0] STACK_PC_IN,
   input wire logic [7:0] RD_IN,
   input wire logic [7:0] RR_IN,
   input wire logic [2:0] BIT_SEL_IN,
   input wire logic NEXT_TWO_WORD_IN,
   input wire logic [7:0] STATUS_IN,
   input wire logic [15:0] PC_OUT,
   input wire logic [7:0] STATUS_OUT,
   input wire logic STATUS_WE_OUT,
   input wire logic BUSY_OUT,
   input wire logic DONE_OUT,
   input wire logic FLUSH_OUT,
   input wire logic PUSH_OUT,
   input wire logic POP_OUT,
   input wire logic [15:0] RET_ADDR_OUT
);
   logic acc;
   logic [15:0] k_ext;
   assign acc = INSTR_VALID_IN && !BUSY_OUT;
   assign k_ext = {{4{OFFSET_IN[11]}}, OFFSET_IN};
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   a_jump_rel_target: assert property (acc && OPCODE_IN == 5'h01 |-> ##1 BUSY_OUT ##1 (DONE_OUT &&
      FLUSH_OUT && PC_OUT == $past(PC_OUT, 2) + $past(k_ext, 2) + 16'h0001)) else $error("jump rel");
   a_jump_abs_time: assert property (acc && OPCODE_IN == 5'h03 |=> BUSY_OUT [*2] ##1 (DONE_OUT &&
      PC_OUT == $past(ABS_ADDR_IN, 3))) else $error("jump abs");
   a_call_push_addr: assert property (acc && OPCODE_IN inside {5'h04, 5'h05} |=> PUSH_OUT &&
      RET_ADDR_OUT == $past(PC_OUT) + 16'h0001) else $error("call push");
   a_call_abs_seq: assert property (acc && OPCODE_IN == 5'h06 |=> (PUSH_OUT &&
      RET_ADDR_OUT == $past(PC_OUT) + 16'h0002) ##3 (DONE_OUT && PC_OUT == $past(ABS_ADDR_IN, 4)))
      else $error("call abs");
   a_ret_stack_pc: assert property (acc && OPCODE_IN == 5'h07 |=> POP_OUT ##3 (DONE_OUT &&
      !STATUS_WE_OUT && PC_OUT == $past(STACK_PC_IN, 4))) else $error("ret");
   a_return_from_interrupt_sets_i: assert property (acc && OPCODE_IN == 5'h08 |-> ##4 (STATUS_WE_OUT &&
      STATUS_OUT == ($past(STATUS_IN, 4) | 8'h80))) else $error("return_from_interrupt");
   a_flow_no_flags: assert property (acc && OPCODE_IN inside {[5'h01:5'h07]} |=>
      !STATUS_WE_OUT [*2]) else $error("flow flags");
   a_cmp_imm_flags: assert property (acc && OPCODE_IN == 5'h0B |=> DONE_OUT && STATUS_WE_OUT &&
      STATUS_OUT[1] == ($past(RD_IN) == $past(RR_IN)) && STATUS_OUT[0] == ($past(RD_IN) < $past(RR_IN)))
      else $error("cmp imm");
   a_cpc_zero_flag: assert property (acc && OPCODE_IN == 5'h0A |=> STATUS_WE_OUT &&
      STATUS_OUT[1] == ($past(RD_IN) - $past(RR_IN) - {7'h00, $past(STATUS_IN[0])} == 8'h00))
      else $error("cpc");
   a_compare_skip_equal_skip_one: assert property (acc && OPCODE_IN == 5'h09 && RD_IN == RR_IN &&
      !NEXT_TWO_WORD_IN |-> ##2 (DONE_OUT && PC_OUT == $past(PC_OUT, 2) + 16'h0002)) else $error("compare_skip_equal");
   a_skip_two_word: assert property (acc && OPCODE_IN == 5'h0D && RR_IN[BIT_SEL_IN] &&
      NEXT_TWO_WORD_IN |-> ##3 (DONE_OUT && PC_OUT == $past(PC_OUT, 3) + 16'h0003)) else $error("skip");
   a_branch_untaken: assert property (acc && OPCODE_IN == 5'h10 && !STATUS_IN[BIT_SEL_IN] |=>
      DONE_OUT && !FLUSH_OUT && PC_OUT == $past(PC_OUT) + 16'h0001) else $error("branch");

   c_return_from_interrupt: cover property (acc && OPCODE_IN == 5'h08);
   c_branch_clear: cover property (acc && OPCODE_IN == 5'h11 && !STATUS_IN[BIT_SEL_IN]);
   c_flush: cover property (DONE_OUT && FLUSH_OUT);
endmodule : bce_exec_monitor

// [verif/branch_compare_exec_test.sv]
// self-checking bench for the control-flow execution block
`timescale 1ns/1ps
module branch_compare_exec_test;
   logic clk, rst_n, valid, iob, two, st_we, busy, done, flush;
   logic [4:0] opc;
   logic [11:0] ofs;
   logic [15:0] abs_a, zp, stk, pc_o, ret_a, pc_m, r;
   logic [7:0] rd, rr, st, st_o;
   logic [2:0] bsel;
   int failures;
   int checked;

   bce_exec i_dut (
      .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .INSTR_VALID_IN(valid), .OPCODE_IN(opc),
      .OFFSET_IN(ofs), .ABS_ADDR_IN(abs_a), .Z_PTR_IN(zp), .STACK_PC_IN(stk), .RD_IN(rd),
      .RR_IN(rr), .BIT_SEL_IN(bsel), .IO_BIT_IN(iob), .NEXT_TWO_WORD_IN(two), .STATUS_IN(st),
      .PC_OUT(pc_o), .STATUS_OUT(st_o), .STATUS_WE_OUT(st_we), .BUSY_OUT(busy),
      .DONE_OUT(done), .FLUSH_OUT(flush), .PUSH_OUT(), .POP_OUT(), .RET_ADDR_OUT(ret_a)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // call right after a rising edge; fl below zero leaves flush unjudged
   task automatic run(input logic [4:0] op, input int n_exp, input logic [15:0] pc_exp,
                      input int fl, input logic we_exp);
      int n;
      logic we;
      valid <= 1'b1;
      opc <= op;
      @(posedge clk);
      valid <= 1'b0;
      n = 1;
      @(negedge clk);
      we = st_we;
      while (done !== 1'b1) begin
         if (n > 6) begin
            failures++;
            final_report();
         end
         @(negedge clk);
         n++;
         we = we | st_we;
      end
      check("cycles", 16'(n), 16'(n_exp));
      check("pc", pc_o, pc_exp);
      if (fl >= 0) check("flush", {15'h0000, flush}, 16'(fl));
      check("status_we", {15'h0000, we}, {15'h0000, we_exp});
      pc_m = pc_exp;
   endtask : run

   task automatic t_flow;
      @(posedge clk);
      ofs <= 12'hFFD;
      run(5'h01, 2, pc_m - 16'h0002, 1, 1'b0);
      @(posedge clk);
      zp <= 16'h1234;
      run(5'h02, 2, 16'h1234, 1, 1'b0);
      @(posedge clk);
      abs_a <= 16'h2468;
      run(5'h03, 3, 16'h2468, 1, 1'b0);
      @(posedge clk);
      ofs <= 12'h010;
      r = pc_m + 16'h0001;
      run(5'h04, 3, pc_m + 16'h0011, 1, 1'b0);
      check("ret_addr", ret_a, r);
      @(posedge clk);
      zp <= 16'h0100;
      r = pc_m + 16'h0001;
      run(5'h05, 3, 16'h0100, 1, 1'b0);
      check("ret_addr", ret_a, r);
      @(posedge clk);
      abs_a <= 16'h0FF0;
      r = pc_m + 16'h0002;
      run(5'h06, 4, 16'h0FF0, 1, 1'b0);
      check("ret_addr", ret_a, r);
      @(posedge clk);
      stk <= 16'h0777;
      run(5'h07, 4, 16'h0777, -1, 1'b0);
      @(posedge clk);
      stk <= 16'h0555;
      st <= 8'h15;
      run(5'h08, 4, 16'h0555, -1, 1'b1);
      check("return_from_interrupt_status", {8'h00, st_o}, 16'h0095);
   endtask : t_flow

   task automatic t_cmp;
      @(posedge clk);
      rd <= 8'h10;
      rr <= 8'h10;
      st <= 8'h01;
      run(5'h0A, 1, pc_m + 16'h0001, 0, 1'b1);
      check("cpc_flags", {8'h00, st_o & 8'h2F}, 16'h0025);
      @(posedge clk);
      rd <= 8'h80;
      rr <= 8'h01;
      st <= 8'h00;
      run(5'h0B, 1, pc_m + 16'h0001, 0, 1'b1);
      check("cpi_flags", {8'h00, st_o & 8'h2F}, 16'h0028);
      @(posedge clk);
      rd <= 8'h42;
      rr <= 8'h42;
      run(5'h0B, 1, pc_m + 16'h0001, 0, 1'b1);
      check("cpi_zero", {8'h00, st_o & 8'h2F}, 16'h0002);
      @(posedge clk);
      two <= 1'b0;
      run(5'h09, 2, pc_m + 16'h0002, -1, 1'b0);
      @(posedge clk);
      two <= 1'b1;
      run(5'h09, 3, pc_m + 16'h0003, -1, 1'b0);
      @(posedge clk);
      rr <= 8'h43;
      run(5'h09, 1, pc_m + 16'h0001, 0, 1'b0);
   endtask : t_cmp

   task automatic t_skip;
      for (int op = 12; op <= 15; op++) begin
         for (int b = 0; b <= 1; b++) begin
            @(posedge clk);
            rr <= (b == 1) ? 8'h20 : 8'hDF;
            iob <= b[0];
            bsel <= 3'h5;
            two <= op[0];
            // even codes skip on a clear bit, odd codes on a set bit
            if (op[0] == b[0]) run(5'(op), 2 + op[0], pc_m + 16'h0002 + op[0], -1, 1'b0);
            else run(5'(op), 1, pc_m + 16'h0001, 0, 1'b0);
         end
      end
   endtask : t_skip

   task automatic t_branch;
      for (int op = 16; op <= 17; op++) begin
         for (int b = 0; b <= 1; b++) begin
            @(posedge clk);
            st <= (b == 1) ? 8'h08 : 8'hF7;
            bsel <= 3'h3;
            ofs <= 12'hFC0;
            if ((op == 16) == (b == 1)) run(5'(op), 2, pc_m - 16'h003F, 1, 1'b0);
            else run(5'(op), 1, pc_m + 16'h0001, 0, 1'b0);
         end
      end
   endtask : t_branch

   initial begin
      failures = 0;
      checked = 0;
      pc_m = 16'h0000;
      r = 16'h0000;
      rst_n = 1'b0;
      valid = 1'b0;
      opc = 5'h00;
      ofs = 12'h000;
      abs_a = 16'h0000;
      zp = 16'h0000;
      stk = 16'h0000;
      rd = 8'h00;
      rr = 8'h00;
      bsel = 3'h0;
      iob = 1'b0;
      two = 1'b0;
      st = 8'h00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_flow();
      t_cmp();
      t_skip();
      t_branch();
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      check("reset_pc", pc_o, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      final_report();
   end
endmodule : branch_compare_exec_test

bind bce_exec bce_exec_monitor i_mon (
   .SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
   .OPCODE_IN(OPCODE_IN), .OFFSET_IN(OFFSET_IN), .ABS_ADDR_IN(ABS_ADDR_IN),
   .STACK_PC_IN(STACK_PC_IN), .RD_IN(RD_IN), .RR_IN(RR_IN), .BIT_SEL_IN(BIT_SEL_IN),
   .NEXT_TWO_WORD_IN(NEXT_TWO_WORD_IN), .STATUS_IN(STATUS_IN), .PC_OUT(PC_OUT),
   .STATUS_OUT(STATUS_OUT), .STATUS_WE_OUT(STATUS_WE_OUT), .BUSY_OUT(BUSY_OUT),
   .DONE_OUT(DONE_OUT), .FLUSH_OUT(FLUSH_OUT), .PUSH_OUT(PUSH_OUT), .POP_OUT(POP_OUT),
   .RET_ADDR_OUT(RET_ADDR_OUT)
);
